// ==== bench/gptg_monitor.sv ====
`timescale 1ns/1ns
module gptg_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic float_en,
  input wire logic epoch_store_en,
  input wire gptg_pkg::gptg_cfg_type cfg,
  input wire gptg_pkg::gptg_bnd_type bnd,
  input wire logic pulse_train_out,
  input wire logic [31:0] scaled_pulse_out,
  input wire logic running,
  input wire logic evt_valid,
  input wire gptg_pkg::gptg_evt_type evt,
  input wire logic cont_valid,
  input wire logic [31:0] cont_data
);
  import gptg_pkg::*;
  logic [7:0] hi_cnt_q;
  // high-level width; saturates so long pulses cannot wrap to 125
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) hi_cnt_q <= 8'h00;
    else if (!pulse_train_out) hi_cnt_q <= 8'h00;
    else if (hi_cnt_q != 8'hff) hi_cnt_q <= hi_cnt_q + 8'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence onset_rec;
    evt_valid && evt.is_onset;
  endsequence
  sequence offset_rec;
    evt_valid && !evt.is_onset;
  endsequence
  min_width_a: assert property ($fell(pulse_train_out) &&
    cfg.duty_mode == D_MIN |-> hi_cnt_q == 8'h7d) else $error("bad width");
  onset_evt_a: assert property ($rose(pulse_train_out) &&
    epoch_store_en |-> ##[0:2] onset_rec) else $error("no onset record");
  offset_evt_a: assert property ($fell(pulse_train_out) &&
    epoch_store_en |-> ##[0:2] offset_rec) else $error("no offset record");
  evt_single_a: assert property (evt_valid |=> !evt_valid)
    else $error("record too long");
  scale_zero_a: assert property (!pulse_train_out |->
    scaled_pulse_out == FLOAT_ZERO) else $error("float not zero");
  scale_bound_a: assert property (pulse_train_out && float_en |->
    scaled_pulse_out >= bnd.scale_min && scaled_pulse_out <= bnd.scale_max)
    else $error("float out of bounds");
  // the stored word follows the float mode that stood at the sample tick
  cont_value_a: assert property (cont_valid |->
    cont_data == ($past(float_en) ? scaled_pulse_out
    : {31'h00000000, pulse_train_out})) else $error("stored value wrong");
  cont_gap_a: assert property (cont_valid |=> !cont_valid [*8])
    else $error("store too often");
  sample_hold_a: assert property ($rose(pulse_train_out) |=>
    pulse_train_out [*8]) else $error("pulse shorter than a sample");
  start_onset_a: assert property ($rose(running) |->
    pulse_train_out) else $error("no onset at start");
  limit_run_a: assert property (cfg.limit_mode != L_NONE &&
    pulse_train_out |-> running) else $error("train not reported");
endmodule : gptg_monitor
bind gptg_top gptg_monitor i_mon (.core_clk(core_clk), .arst_n(arst_n),
  .float_en(float_en), .epoch_store_en(epoch_store_en), .cfg(cfg),
  .bnd(bnd), .pulse_train_out(pulse_train_out), .running(running),
  .scaled_pulse_out(scaled_pulse_out), .evt_valid(evt_valid), .evt(evt),
  .cont_valid(cont_valid), .cont_data(cont_data));

// ==== bench/gptg_upstream.sv ====
`timescale 1ns/1ns
module gptg_upstream (
  input wire logic core_clk,
  output logic enable_in,
  output logic rt_start,
  output logic rt_stop
);
  initial enable_in = 1'b0;
  initial rt_start = 1'b0;
  initial rt_stop = 1'b0;
  // level moves just after an edge; the sync chain absorbs the rest
  task automatic set_level(input logic v);
    @(posedge core_clk);
    #1 enable_in = v;
  endtask : set_level
  // one-cycle strobe, dropped only after the edge that samples it
  task automatic strobe(input logic stop);
    @(posedge core_clk);
    #1;
    if (stop) rt_stop = 1'b1;
    else rt_start = 1'b1;
    @(posedge core_clk);
    #1;
    rt_start = 1'b0;
    rt_stop = 1'b0;
  endtask : strobe
endmodule : gptg_upstream

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import gptg_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, rt_if_en = 1'b1, rt_enable = 1'b0;
  logic float_en = 1'b1, epoch_store_en = 1'b1, cont_store_en = 1'b1;
  logic enable_in, rt_start, rt_stop, pulse_train_out, running;
  logic evt_valid, cont_valid;
  logic [31:0] scaled_pulse_out, cont_data;
  gptg_cfg_type cfg;
  gptg_bnd_type bnd;
  gptg_evt_type evt;
  int failures = 0, check_count = 0, hi, per, ons;
  always #4 core_clk = ~core_clk;
  gptg_upstream i_up (.core_clk(core_clk), .enable_in(enable_in),
    .rt_start(rt_start), .rt_stop(rt_stop));
  gptg_top i_dut (.core_clk(core_clk), .arst_n(arst_n),
    .enable_in(enable_in), .rt_if_en(rt_if_en), .rt_enable(rt_enable),
    .rt_start(rt_start), .rt_stop(rt_stop), .float_en(float_en),
    .epoch_store_en(epoch_store_en), .cont_store_en(cont_store_en),
    .cfg(cfg), .bnd(bnd), .pulse_train_out(pulse_train_out),
    .scaled_pulse_out(scaled_pulse_out), .running(running),
    .evt_valid(evt_valid), .evt(evt), .cont_valid(cont_valid),
    .cont_data(cont_data));
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // cycles the watched level holds; onsets seen meanwhile, bounded.
  // once one wait runs out the rest return at once, keeping the run short
  bit hung = 1'b0;
  task automatic span(input logic sel, output int n, output int r);
    logic v, p;
    v = sel ? running : pulse_train_out;
    p = sel ? 1'b0 : pulse_train_out;
    n = 0;
    r = 0;
    while ((sel ? running : pulse_train_out) === v && n < 20000 &&
           !hung) begin
      step(1);
      n++;
      if (pulse_train_out === 1'b1 && p !== 1'b1) r++;
      p = pulse_train_out;
    end
    if (n >= 20000) begin
      failures++;
      hung = 1'b1;
      $display("[FAIL] %0t wait ran out", $time);
    end
  endtask : span
  // reconfigure while idle, then measure one high time and one period
  task automatic shape(input gptg_unit_type ru, input logic [31:0] rv,
    input gptg_duty_type dm, input gptg_unit_type hu,
    input logic [31:0] hv, input int eh, input int ep);
    rt_enable = 1'b0;
    step(400);
    cfg.rate_unit = ru;
    cfg.rate_val = rv;
    cfg.duty_mode = dm;
    cfg.high_unit = hu;
    cfg.high_val = hv;
    step(300);
    rt_enable = 1'b1;
    span(1'b0, hi, ons);
    if (pulse_train_out !== 1'b1) span(1'b0, hi, ons);
    span(1'b0, hi, ons);
    span(1'b0, per, ons);
    check(hi, eh);
    check(hi + per, ep);
    $display("shape test done");
  endtask : shape
  initial begin
    cfg = '0;
    cfg.limit_unit = U_SAMP;
    cfg.scale = 32'h459c4000;
    bnd = '0;
    bnd.rate_max = '1;
    bnd.high_max = '1;
    bnd.limit_max = '1;
    bnd.scale_min = DEF_SCALE;
    bnd.scale_max = 32'h447a0000;
    step(12);
    arst_n = 1'b1;
    step(200);
    shape(U_HZ, 32'h05f5e100, D_TIME, U_SAMP, 32'h00000bb8, 375,
      1250);
    shape(U_KHZ, 32'h000186a0, D_PCT, U_SAMP, 32'h00004e20, 250,
      1250);
    shape(U_BPM, 32'hb2d05e00, D_PCT, U_SAMP, DEF_PCT, 1250,
      2500);
    shape(U_MS, 32'h0000000a, D_MIN, U_SAMP, 32'h00000000, 125,
      1250);
    shape(U_US, 32'h00002710, D_TIME, U_US, 32'h00000fa0, 500,
      1250);
    // the onset record and the stored float stand in the onset cycle
    check({30'h00000000, evt_valid, evt.is_onset}, 32'h00000003);
    check(cont_data, 32'h447a0000);
    // float and events off: the stored word falls back to the logic level
    float_en = 1'b0;
    epoch_store_en = 1'b0;
    shape(U_SAMP, 32'h00002710, D_TIME, U_MS, 32'h00000003, 375,
      1250);
    check(scaled_pulse_out, FLOAT_ZERO);
    check(cont_data, 32'h00000001);
    check({30'h00000000, evt_valid, cont_valid}, 32'h00000001);
    // re-enable only once the pulse has gone low
    rt_enable = 1'b0;
    step(200);
    float_en = 1'b1;
    epoch_store_en = 1'b1;
    bnd.rate_max = 32'h00002710;
    shape(U_SAMP, 32'h0000c350, D_TIME, U_SAMP, 32'h00000bb8, 375,
      1250);
    check(scaled_pulse_out, 32'h447a0000);
    // timed train from a held input level: must not retrigger
    rt_enable = 1'b0;
    step(400);
    cont_store_en = 1'b0;
    cfg.limit_mode = L_TIMED;
    cfg.limit_val = 32'h000061a8;
    cfg.scale = 32'h40000000;
    step(300);
    i_up.set_level(1'b1);
    span(1'b1, hi, ons);
    span(1'b1, hi, ons);
    check(hi, 3125);
    check(ons, 3);
    check(cont_valid, 1'b0);
    step(1000);
    check(running, 1'b0);
    i_up.set_level(1'b0);
    $display("timed test done");
    cont_store_en = 1'b1;
    cfg.limit_mode = L_COUNT;
    cfg.limit_val = 32'h000007d0;
    step(300);
    i_up.strobe(1'b0);
    span(1'b1, hi, ons);
    span(1'b1, hi, ons);
    check(ons, 2);
    $display("count test done");
    // long counted train cut short by a stop strobe
    cfg.limit_val = 32'h000186a0;
    step(300);
    i_up.strobe(1'b0);
    step(500);
    check(running, 1'b1);
    i_up.strobe(1'b1);
    span(1'b1, hi, ons);
    check({31'h0, hi < 260}, 32'h1);
    $display("stop test done");
    tally_and_finish();
  end
endmodule : testbench

// ==== design/gptg_div.sv ====
`timescale 1ns/1ns
// free-running restoring divider; republishes num/den every 65 cycles
module gptg_div (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [63:0] num,
  input wire logic [31:0] den,
  output logic [31:0] quo_q
);
  import gptg_pkg::*;

  logic [6:0] cnt_q;
  logic [63:0] n_q;
  logic [32:0] r_q;
  logic [31:0] d_q;
  logic [32:0] trial;
  logic ge;

  always_comb begin
    trial = {r_q[31:0], n_q[63]};
    ge = trial >= {1'b0, d_q};
  end

  // step counter, one load cycle then one bit per cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= '0;
    else cnt_q <= (cnt_q == DIV_STEPS) ? '0 : cnt_q + 7'h01;
  end

  // operands are latched at load so mid-run changes do not corrupt
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      n_q <= '0;
      r_q <= '0;
      d_q <= '0;
    end else if (cnt_q == '0) begin
      n_q <= num;
      r_q <= '0;
      d_q <= den;
    end else begin
      n_q <= {n_q[62:0], ge};
      r_q <= ge ? trial - {1'b0, d_q} : trial;
    end
  end

  // saturate on overflow and never publish less than one sample
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) quo_q <= ONE_SAMPLE;
    else if (cnt_q == '0) begin
      if (n_q[63:32] != '0) quo_q <= '1;
      else if (n_q[31:0] == '0) quo_q <= ONE_SAMPLE;
      else quo_q <= n_q[31:0];
    end
  end
endmodule : gptg_div

// ==== design/gptg_pkg.sv ====
package gptg_pkg;
  // clock and sample timing
  localparam longint CLK_HZ = 125000000;
  localparam longint SAMPLE_HZ = 1000000;
  localparam int SAMPLE_DIV = int'(CLK_HZ / SAMPLE_HZ);
  localparam logic [7:0] SAMPLE_DIV_LAST = 8'(SAMPLE_DIV - 1);
  // configured values other than the float scale are fixed point with three decimals
  localparam longint MILLI = 1000;
  localparam longint MICRO_DEN = 1000000;
  localparam longint NANO_DEN = 1000000000;
  localparam longint SEC_PER_MIN = 60;
  localparam longint PCT_FULL = 100000; // 100.000 percent
  localparam logic [31:0] DEF_PCT = 32'h0000c350; // 50.000 percent
  localparam logic [31:0] DEF_SCALE = 32'h3f800000; // 1.0 float
  localparam logic [31:0] ONE_SAMPLE = 32'h00000001;
  localparam logic [31:0] FLOAT_ZERO = 32'h00000000;
  localparam logic [6:0] DIV_STEPS = 7'h40;

  typedef enum logic [2:0] {
    U_HZ, U_KHZ, U_BPM, U_MIN, U_SEC, U_MS, U_US, U_SAMP
  } gptg_unit_type;
  typedef enum logic [1:0] {D_PCT, D_TIME, D_MIN} gptg_duty_type;
  typedef enum logic [1:0] {L_NONE, L_TIMED, L_COUNT} gptg_limit_type;

  typedef struct packed {
    gptg_unit_type rate_unit; // hz/khz/bpm select frequency, rest period
    logic [31:0] rate_val;
    gptg_duty_type duty_mode;
    gptg_unit_type high_unit;
    logic [31:0] high_val; // percent or time, thousandths
    gptg_limit_type limit_mode;
    gptg_unit_type limit_unit;
    logic [31:0] limit_val; // time or pulse count, thousandths
    logic [31:0] scale; // ieee single, positive
  } gptg_cfg_type;

  typedef struct packed {
    logic [31:0] rate_min;
    logic [31:0] rate_max;
    logic [31:0] high_min;
    logic [31:0] high_max;
    logic [31:0] limit_min;
    logic [31:0] limit_max;
    logic [31:0] scale_min;
    logic [31:0] scale_max;
  } gptg_bnd_type;

  typedef struct packed {
    logic is_onset;
    logic [31:0] stamp; // sample index
  } gptg_evt_type;

  typedef struct packed {
    logic [63:0] num;
    logic [31:0] den;
  } gptg_ratio_type;

  // value in a unit to a sample-count ratio num/den
  function automatic gptg_ratio_type gptg_ratio(gptg_unit_type u,
                                                logic [31:0] v);
    gptg_ratio_type r;
    logic [63:0] v64;
    v64 = {32'h00000000, v};
    r.num = v64 * 64'(SAMPLE_HZ);
    r.den = 32'(MILLI);
    unique case (u)
      U_HZ: begin
        r.num = 64'(SAMPLE_HZ * MILLI);
        r.den = v;
      end
      U_KHZ: begin
        r.num = 64'(SAMPLE_HZ);
        r.den = v;
      end
      U_BPM: begin
        r.num = 64'(SAMPLE_HZ * MILLI * SEC_PER_MIN);
        r.den = v;
      end
      U_MIN: r.num = v64 * 64'(SAMPLE_HZ * SEC_PER_MIN);
      U_SEC: r.num = v64 * 64'(SAMPLE_HZ);
      U_MS: r.den = 32'(MICRO_DEN);
      U_US: r.den = 32'(NANO_DEN);
      U_SAMP: r.num = v64;
    endcase
    return r;
  endfunction : gptg_ratio

  // confine a value to its bounds; works for positive floats too
  function automatic logic [31:0] gptg_clamp(logic [31:0] v,
                                             logic [31:0] lo,
                                             logic [31:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction : gptg_clamp
endpackage : gptg_pkg

// ==== design/gptg_top.sv ====
// Functional notes
// - The interval may be set as a frequency in Hz, kHz or BPM.
// - It may instead be a period in min, s, ms, us or samples.
// - Percentage mode holds the pulse high for a share, 50 by default.
// - Fixed-time mode holds the pulse high for a set time, rate aside.
// - Minimum mode makes every pulse exactly one sample wide.
// - With no limit, pulses run while either enable is on.
// - Timed mode runs each triggered train for the set time, then stops.
// - Count mode ends each triggered train after the set pulse count.
// - A run-time stop ends a timed or counted train at once.
// - Timed and count trains start only on a trigger rising edge.
// - A train started from the input is reported as running.
// - When enabled, a float output is the pulse times a bounded scale.
// - Rate, high time, limit and scale stay within their bounds.
// - With event storage on, each onset and offset emits a record.
// - Continuous storage keeps each sample, float if enabled else logic.
// - The main output is one logic signal with one value per sample.
`timescale 1ns/1ns
module gptg_top (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic enable_in,
  input wire logic rt_if_en,
  input wire logic rt_enable,
  input wire logic rt_start,
  input wire logic rt_stop,
  input wire logic float_en,
  input wire logic epoch_store_en,
  input wire logic cont_store_en,
  input wire gptg_pkg::gptg_cfg_type cfg,
  input wire gptg_pkg::gptg_bnd_type bnd,
  output logic pulse_train_out,
  output logic [31:0] scaled_pulse_out,
  output logic running,
  output logic evt_valid,
  output gptg_pkg::gptg_evt_type evt,
  output logic cont_valid,
  output logic [31:0] cont_data
);
  import gptg_pkg::*;

  logic [7:0] div_q;
  logic tick_q;
  logic en_s1_q, en_s2_q, en_s3_q, en_lvl_q, en_rise;
  logic trig_q, stop_q;
  logic [31:0] rate_v, high_v, limit_v, scale_v;
  gptg_ratio_type rate_r, high_r, limit_r;
  logic [31:0] period_s, high_t_s, high_p_s, limit_s, high_s;
  logic active_q;
  logic [31:0] ph_q, el_q, cnt_q, stamp_q;
  logic [31:0] ph_d, el_d, cnt_d;
  logic go_d, lvl_d, start, level_run;

  // sample-rate enable from the core clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= (div_q == SAMPLE_DIV_LAST) ? '0 : div_q + 8'h01;
      tick_q <= (div_q == SAMPLE_DIV_LAST);
    end
  end

  // trigger input comes from another domain; accept a level once stable
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_s3_q <= 1'b0;
      en_lvl_q <= 1'b0;
    end else begin
      en_s1_q <= enable_in;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
      if (en_s2_q == en_s3_q) en_lvl_q <= en_s3_q;
    end
  end

  assign en_rise = (en_s2_q == en_s3_q) && en_s3_q && !en_lvl_q;

  // edges arrive between sample ticks; hold them until the next tick.
  // a new edge in the clearing tick wins over the clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (en_rise || (rt_if_en && rt_start)) trig_q <= 1'b1;
      else if (tick_q) trig_q <= 1'b0;
      if (rt_if_en && rt_stop) stop_q <= 1'b1;
      else if (tick_q) stop_q <= 1'b0;
    end
  end

  // bounded values, applied continuously so run-time edits stay legal
  always_comb begin
    rate_v = gptg_clamp(cfg.rate_val, bnd.rate_min, bnd.rate_max);
    high_v = gptg_clamp(cfg.high_val, bnd.high_min, bnd.high_max);
    limit_v = gptg_clamp(cfg.limit_val, bnd.limit_min,
                         bnd.limit_max);
    scale_v = gptg_clamp(cfg.scale, bnd.scale_min, bnd.scale_max);
  end

  // unit conversion to sample-count ratios
  always_comb begin
    rate_r = gptg_ratio(cfg.rate_unit, rate_v);
    high_r = gptg_ratio(cfg.high_unit, high_v);
    limit_r = gptg_ratio((cfg.limit_mode == L_COUNT) ? U_SAMP :
                         cfg.limit_unit, limit_v);
  end

  gptg_div u_div_rate (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .num(rate_r.num),
    .den(rate_r.den),
    .quo_q(period_s)
  );

  gptg_div u_div_high (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .num(high_r.num),
    .den(high_r.den),
    .quo_q(high_t_s)
  );

  // percentage of the current period; lags a new rate by two divisions
  gptg_div u_div_pct (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .num({32'h00000000, period_s} * {32'h00000000, high_v}),
    .den(32'(PCT_FULL)),
    .quo_q(high_p_s)
  );

  gptg_div u_div_limit (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .num(limit_r.num),
    .den(limit_r.den),
    .quo_q(limit_s)
  );

  // high time in samples by duty mode
  always_comb begin
    unique case (cfg.duty_mode)
      D_PCT: high_s = high_p_s;
      D_TIME: high_s = high_t_s;
      D_MIN: high_s = ONE_SAMPLE;
      default: high_s = ONE_SAMPLE;
    endcase
  end

  assign level_run = en_lvl_q || (rt_if_en && rt_enable);

  // next sample of the train; a start restarts phase at the onset
  always_comb begin
    start = (cfg.limit_mode == L_NONE) ? (level_run && !active_q)
                                       : trig_q;
    ph_d = ph_q;
    el_d = el_q;
    cnt_d = cnt_q;
    go_d = 1'b0;
    if (start) begin
      ph_d = '0;
      el_d = '0;
      cnt_d = '0;
      go_d = 1'b1;
    end else if (active_q) begin
      ph_d = (ph_q >= period_s - ONE_SAMPLE) ? '0 : ph_q + ONE_SAMPLE;
      el_d = el_q + ONE_SAMPLE;
      go_d = 1'b1;
    end
    unique case (cfg.limit_mode)
      L_NONE: if (!level_run) go_d = 1'b0;
      L_TIMED: if (el_d >= limit_s) go_d = 1'b0;
      L_COUNT: if (ph_d == '0 && cnt_d >= limit_s) go_d = 1'b0;
      default: go_d = 1'b0;
    endcase
    if (stop_q && cfg.limit_mode != L_NONE) go_d = 1'b0;
    lvl_d = go_d && (ph_d < high_s);
  end

  // train state, advanced once per sample
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= 1'b0;
      ph_q <= '0;
      el_q <= '0;
      cnt_q <= '0;
    end else if (tick_q) begin
      active_q <= go_d;
      ph_q <= ph_d;
      el_q <= el_d;
      cnt_q <= (go_d && ph_d == '0) ? cnt_d + ONE_SAMPLE : cnt_d;
    end
  end

  // sample timestamp for stored events
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) stamp_q <= '0;
    else if (tick_q) stamp_q <= stamp_q + ONE_SAMPLE;
  end

  // outputs, one value per sample
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_train_out <= 1'b0;
      scaled_pulse_out <= FLOAT_ZERO;
      running <= 1'b0;
    end else if (tick_q) begin
      pulse_train_out <= lvl_d;
      scaled_pulse_out <= (float_en && lvl_d) ? scale_v
                                              : FLOAT_ZERO;
      running <= go_d;
    end
  end

  // storage records; each valid is a one-cycle strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_valid <= 1'b0;
      evt <= '0;
      cont_valid <= 1'b0;
      cont_data <= '0;
    end else begin
      evt_valid <= tick_q && epoch_store_en &&
                   (lvl_d != pulse_train_out);
      cont_valid <= tick_q && cont_store_en;
      if (tick_q) begin
        evt.is_onset <= lvl_d;
        evt.stamp <= stamp_q;
        cont_data <= float_en ? ((lvl_d) ? scale_v : FLOAT_ZERO)
                              : {31'h00000000, lvl_d};
      end
    end
  end
endmodule : gptg_top
